// >>> logic/ica_pkg.sv
package ica_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [9:0] OFS_CSR_DATA = 10'h300;
  localparam logic [9:0] OFS_CSR_CMD = 10'h304;
  localparam logic [9:0] OFS_RAM_ADDR_LEN = 10'h308;
  localparam logic [9:0] OFS_RAM_CMD = 10'h30C;

  // ==========================================================
  // Field positions
  localparam int CMD_PENDING_BIT = 31;
  localparam int CMD_DIR_BIT = 30;
  localparam int CMD_SIZE_HI = 18;
  localparam int CMD_SIZE_LO = 16;
  localparam int CMD_ADDR_HI = 15;
  localparam int CMD_ADDR_LO = 0;
  localparam int RAM_LEN_HI = 31;
  localparam int RAM_LEN_LO = 16;
  localparam int RAM_ADDR_HI = 15;
  localparam int RAM_ADDR_LO = 0;
  localparam int RAM_BUSY_BIT = 31;

  // ==========================================================
  // Encodings and reset values
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;
  localparam logic [2:0] SIZE_BYTE = 3'h1;
  localparam logic [2:0] SIZE_WORD = 3'h2;
  localparam logic [2:0] SIZE_DWORD = 3'h4;
  localparam logic [2:0] BYTES_PER_DWORD = 3'h4;
  localparam logic [31:0] RST_DATA = 32'h0000_0000;
  localparam logic [2:0] RST_SIZE = 3'h0;
  localparam logic [15:0] RST_ADDR = 16'h0000;
  localparam logic [15:0] RST_LEN = 16'h0000;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CSR_WAIT,
    ST_RAM_WAIT,
    ST_RAM_PUSH
  } ica_state_e;

  typedef struct packed {
    logic write;
    logic [15:0] addr;
    logic [3:0] byte_en;
    logic [31:0] wdata;
  } ica_core_req_s;

  typedef struct packed {
    logic [31:0] data;
    logic [2:0] bytes;
  } ica_fifo_word_s;

endpackage

// >>> logic/ica_core_access.sv
// Behaviour
// - Writing pending one starts single core access.
// - Pending stays set during access, self-clears.
// - Read clears pending only with data valid.
// - Writing pending zero loads direction, size, address; starts nothing.
// - Direction bit: zero write, one read.
// - Size field selects 1, 2, 4 bytes.
// - Address field is core byte offset.
// - Read length decrements per fetched byte.
// - Read address increments per fetched byte.
// - Data sits low; device aligns toward core.
// - Data read returns core or written value.
// - Busy one starts RAM read, self-clears.
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module ica_core_access (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Host register port
  input wire logic [9:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [31:0] reg_rdata_out,
  // Core register and RAM space
  output logic core_req_valid_out,
  output ica_pkg::ica_core_req_s core_req_out,
  input wire logic core_ack_in,
  input wire logic [31:0] core_rdata_in,
  // Read FIFO fill side
  output logic fifo_valid_out,
  output ica_pkg::ica_fifo_word_s fifo_word_out,
  input wire logic fifo_ready_in,
  // Status
  output logic access_pending_out,
  output logic ram_read_in_progress_out
);

  // ==========================================================
  // Helpers
  function automatic logic [3:0] lane_mask(input logic [2:0] size,
                                           input logic [1:0] lo);
    logic [3:0] base;
    base = 4'hF;
    case (size)
      ica_pkg::SIZE_BYTE: base = 4'h1;
      ica_pkg::SIZE_WORD: base = 4'h3;
      default: base = 4'hF;
    endcase
    lane_mask = 4'((base << lo));
  endfunction

  function automatic logic [31:0] low_mask(input logic [2:0] size);
    logic [31:0] m;
    m = 32'hFFFF_FFFF;
    case (size)
      ica_pkg::SIZE_BYTE: m = 32'h0000_00FF;
      ica_pkg::SIZE_WORD: m = 32'h0000_FFFF;
      default: m = 32'hFFFF_FFFF;
    endcase
    low_mask = m;
  endfunction

  // ==========================================================
  // State
  ica_pkg::ica_state_e state_q, state_d;
  logic pending_q;
  logic dir_q;
  logic [2:0] size_q;
  logic [15:0] core_register_byte_offset_q;
  logic [31:0] wr_data_q;
  logic [31:0] rd_data_q;
  logic ram_busy_q;
  logic [15:0] ram_len_q;
  logic [15:0] ram_addr_q;
  logic [31:0] reg_rdata_q;
  logic core_valid_q;
  ica_pkg::ica_core_req_s core_req_q;
  logic fifo_valid_q;
  ica_pkg::ica_fifo_word_s fifo_word_q;

  // ==========================================================
  // Register decode
  wire logic wr_data = reg_write_in && (reg_addr_in == ica_pkg::OFS_CSR_DATA);
  wire logic wr_cmd = reg_write_in && (reg_addr_in == ica_pkg::OFS_CSR_CMD);
  wire logic wr_ram_al = reg_write_in &&
                         (reg_addr_in == ica_pkg::OFS_RAM_ADDR_LEN);
  wire logic wr_ram_cmd = reg_write_in &&
                          (reg_addr_in == ica_pkg::OFS_RAM_CMD);

  // Command writes are dropped while an access is pending
  wire logic cmd_accept = wr_cmd && !pending_q;
  // A zero in the pending bit never starts or stops anything
  wire logic csr_start = cmd_accept &&
                         reg_wdata_in[ica_pkg::CMD_PENDING_BIT];
  wire logic ram_start = wr_ram_cmd && !ram_busy_q &&
                         reg_wdata_in[ica_pkg::RAM_BUSY_BIT];
  wire logic al_accept = wr_ram_al && !ram_busy_q;

  wire logic [31:0] cmd_view = {pending_q, dir_q, 11'h000, size_q,
                                core_register_byte_offset_q};
  // Data register view depends on direction
  wire logic [31:0] data_view = (dir_q == ica_pkg::DIR_READ) ?
                                rd_data_q : wr_data_q;
  wire logic [31:0] al_view = {ram_len_q, ram_addr_q};
  wire logic [31:0] ram_cmd_view = {ram_busy_q, 31'h0000_0000};

  wire logic [31:0] read_mux =
    (reg_addr_in == ica_pkg::OFS_CSR_DATA) ? data_view :
    (reg_addr_in == ica_pkg::OFS_CSR_CMD) ? cmd_view :
    (reg_addr_in == ica_pkg::OFS_RAM_ADDR_LEN) ? al_view :
    (reg_addr_in == ica_pkg::OFS_RAM_CMD) ? ram_cmd_view :
    ica_pkg::READ_ZERO;

  // ==========================================================
  // Core side alignment
  wire logic [4:0] csr_shift = {core_register_byte_offset_q[1:0], 3'b000};
  // Low-order host data is moved onto the addressed lanes
  wire logic [31:0] csr_wdata_al =
    32'((wr_data_q & low_mask(size_q)) << csr_shift);
  wire logic [31:0] csr_rdata_al =
    32'(core_rdata_in >> csr_shift) & low_mask(size_q);

  // Bytes from the next address up to the end of its dword
  wire logic [2:0] to_word_end = ica_pkg::BYTES_PER_DWORD -
                                 {1'b0, ram_addr_q[1:0]};
  wire logic [2:0] ram_step = (ram_len_q < {13'h0000, to_word_end}) ?
                              ram_len_q[2:0] : to_word_end;
  wire logic [4:0] ram_shift = {ram_addr_q[1:0], 3'b000};
  wire logic [31:0] ram_rdata_al = 32'(core_rdata_in >> ram_shift);

  // ==========================================================
  // Sequencer
  wire logic idle_csr = (state_q == ica_pkg::ST_IDLE) && pending_q;
  wire logic idle_ram = (state_q == ica_pkg::ST_IDLE) && !pending_q &&
                        ram_busy_q && (ram_len_q != ica_pkg::RST_LEN);
  wire logic ram_done_idle = (state_q == ica_pkg::ST_IDLE) && !pending_q &&
                             ram_busy_q && (ram_len_q == ica_pkg::RST_LEN);
  wire logic csr_ack = (state_q == ica_pkg::ST_CSR_WAIT) && core_ack_in;
  wire logic ram_ack = (state_q == ica_pkg::ST_RAM_WAIT) && core_ack_in;
  wire logic fifo_take = fifo_valid_q && fifo_ready_in;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ica_pkg::ST_IDLE: begin
        if (idle_csr) begin
          state_d = ica_pkg::ST_CSR_WAIT;
        end else if (idle_ram) begin
          state_d = ica_pkg::ST_RAM_WAIT;
        end
      end
      ica_pkg::ST_CSR_WAIT: begin
        if (core_ack_in) begin
          state_d = ica_pkg::ST_IDLE;
        end
      end
      ica_pkg::ST_RAM_WAIT: begin
        if (core_ack_in) begin
          state_d = ica_pkg::ST_RAM_PUSH;
        end
      end
      ica_pkg::ST_RAM_PUSH: begin
        if (fifo_take) begin
          state_d = ica_pkg::ST_IDLE;
        end
      end
      default: state_d = ica_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= ica_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // Single core register access
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pending_q <= 1'b0;
      dir_q <= ica_pkg::DIR_WRITE;
      size_q <= ica_pkg::RST_SIZE;
      core_register_byte_offset_q <= ica_pkg::RST_ADDR;
    end else begin
      if (cmd_accept) begin
        dir_q <= reg_wdata_in[ica_pkg::CMD_DIR_BIT];
        size_q <= reg_wdata_in[ica_pkg::CMD_SIZE_HI:ica_pkg::CMD_SIZE_LO];
        core_register_byte_offset_q <= reg_wdata_in[ica_pkg::CMD_ADDR_HI:ica_pkg::CMD_ADDR_LO];
      end
      // Pending drops on the same edge that captures read data
      if (csr_start) begin
        pending_q <= 1'b1;
      end else if (csr_ack) begin
        pending_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_data_q <= ica_pkg::RST_DATA;
      rd_data_q <= ica_pkg::RST_DATA;
    end else begin
      if (wr_data && !pending_q) begin
        wr_data_q <= reg_wdata_in;
      end
      if (csr_ack && (dir_q == ica_pkg::DIR_READ)) begin
        rd_data_q <= csr_rdata_al;
      end
    end
  end

  // ==========================================================
  // Process RAM burst read
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ram_busy_q <= 1'b0;
      ram_len_q <= ica_pkg::RST_LEN;
      ram_addr_q <= ica_pkg::RST_ADDR;
    end else begin
      if (al_accept) begin
        ram_len_q <= reg_wdata_in[ica_pkg::RAM_LEN_HI:ica_pkg::RAM_LEN_LO];
        ram_addr_q <= reg_wdata_in[ica_pkg::RAM_ADDR_HI:ica_pkg::RAM_ADDR_LO];
      end else if (ram_ack) begin
        ram_len_q <= ram_len_q - {13'h0000, ram_step};
        ram_addr_q <= ram_addr_q + {13'h0000, ram_step};
      end
      if (ram_start) begin
        ram_busy_q <= 1'b1;
      end else if (ram_done_idle) begin
        ram_busy_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Core request and FIFO outputs
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      core_valid_q <= 1'b0;
      core_req_q <= '0;
    end else begin
      if (idle_csr) begin
        core_valid_q <= 1'b1;
        core_req_q.write <= (dir_q == ica_pkg::DIR_WRITE);
        core_req_q.addr <= core_register_byte_offset_q;
        core_req_q.byte_en <= lane_mask(size_q, core_register_byte_offset_q[1:0]);
        core_req_q.wdata <= csr_wdata_al;
      end else if (idle_ram) begin
        core_valid_q <= 1'b1;
        core_req_q.write <= 1'b0;
        core_req_q.addr <= {ram_addr_q[15:2], 2'b00};
        core_req_q.byte_en <= lane_mask(ica_pkg::SIZE_DWORD, 2'b00);
        core_req_q.wdata <= ica_pkg::RST_DATA;
      end else if (core_ack_in) begin
        core_valid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      fifo_valid_q <= 1'b0;
      fifo_word_q <= '0;
    end else begin
      if (ram_ack) begin
        fifo_valid_q <= 1'b1;
        fifo_word_q.data <= ram_rdata_al;
        fifo_word_q.bytes <= ram_step;
      end else if (fifo_take) begin
        fifo_valid_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Register read data, one cycle after the strobe
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_q <= ica_pkg::READ_ZERO;
    end else if (reg_read_in) begin
      reg_rdata_q <= read_mux;
    end else begin
      reg_rdata_q <= ica_pkg::READ_ZERO;
    end
  end

  assign reg_rdata_out = reg_rdata_q;
  assign core_req_valid_out = core_valid_q;
  assign core_req_out = core_req_q;
  assign fifo_valid_out = fifo_valid_q;
  assign fifo_word_out = fifo_word_q;
  assign access_pending_out = pending_q;
  assign ram_read_in_progress_out = ram_busy_q;

endmodule

`default_nettype wire

// >>> bench/ica_core_access_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ica_core_access_monitor (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [9:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic core_req_valid_out,
  input wire ica_pkg::ica_core_req_s core_req_out,
  input wire logic core_ack_in,
  input wire logic fifo_valid_out,
  input wire ica_pkg::ica_fifo_word_s fifo_word_out,
  input wire logic fifo_ready_in,
  input wire logic access_pending_out,
  input wire logic ram_read_in_progress_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  wire logic cmd_wr = reg_write_in && reg_addr_in == ica_pkg::OFS_CSR_CMD;
  wire logic ram_wr = reg_write_in && reg_addr_in == ica_pkg::OFS_RAM_CMD;

  pend_start_a: assert property (
    cmd_wr && reg_wdata_in[31] && !access_pending_out |=> access_pending_out
  ) else $error("pending not set by start");
  zero_write_a: assert property (
    cmd_wr && !reg_wdata_in[31] && !access_pending_out |=> !access_pending_out
  ) else $error("pending set by zero write");
  req_launch_a: assert property (
    $rose(access_pending_out) && !ram_read_in_progress_out
    |=> core_req_valid_out) else $error("no core request after start");
  pend_hold_a: assert property (
    access_pending_out && !core_ack_in |=> access_pending_out
  ) else $error("pending dropped early");
  pend_clear_a: assert property (
    $fell(access_pending_out) |-> $past(core_ack_in)
  ) else $error("pending cleared without answer");
  req_stable_a: assert property (
    core_req_valid_out && !core_ack_in
    |=> core_req_valid_out && $stable(core_req_out)
  ) else $error("core request changed while waiting");
  ack_drop_a: assert property (
    core_req_valid_out && core_ack_in |=> !core_req_valid_out
  ) else $error("core request held after answer");
  push_hold_a: assert property (
    fifo_valid_out && !fifo_ready_in
    |=> fifo_valid_out && $stable(fifo_word_out)
  ) else $error("fifo word changed while stalled");
  ram_start_a: assert property (
    ram_wr && reg_wdata_in[31] && !ram_read_in_progress_out
    |=> ram_read_in_progress_out) else $error("ram read not started");
  ram_align_a: assert property (
    core_req_valid_out && ram_read_in_progress_out && !access_pending_out
    |-> core_req_out.addr[1:0] == 2'h0 && core_req_out.byte_en == 4'hF
  ) else $error("ram request not dword aligned");
  rd_idle_a: assert property (
    !reg_read_in |=> reg_rdata_out == 32'h0
  ) else $error("read data outside answer cycle");
endmodule

bind ica_core_access ica_core_access_monitor ica_core_access_monitor_i (
  .sys_clk_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_write_in,
  .reg_read_in, .reg_rdata_out, .core_req_valid_out, .core_req_out,
  .core_ack_in, .fifo_valid_out, .fifo_word_out, .fifo_ready_in,
  .access_pending_out, .ram_read_in_progress_out);
`default_nettype wire

// >>> bench/ica_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module ica_core_model (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic req_valid_in,
  input wire ica_pkg::ica_core_req_s req_in,
  input wire logic [3:0] wait_in,
  output logic ack_out,
  output logic [31:0] rdata_out,
  output var ica_pkg::ica_core_req_s last_req_out
);
  // ==========================================================
  // Core space: byte at address X reads as X[7:0]
  logic [3:0] cnt_q;
  wire logic [7:0] base = {req_in.addr[7:2], 2'h0};
  wire logic take = req_valid_in && !ack_out && cnt_q == wait_in;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q <= 4'h0;
      ack_out <= 1'h0;
      rdata_out <= 32'h0;
      last_req_out <= '0;
    end else if (take) begin
      cnt_q <= 4'h0;
      ack_out <= 1'h1;
      rdata_out <= {base + 8'h3, base + 8'h2, base + 8'h1, base};
      last_req_out <= req_in;
    end else begin
      ack_out <= 1'h0;
      // Data lines are only valid with the answer
      rdata_out <= ~rdata_out;
      cnt_q <= (req_valid_in && !ack_out) ? cnt_q + 4'h1 : 4'h0;
    end
  end
endmodule
`default_nettype wire

// >>> bench/tb_ica_core_access.sv
`timescale 1ns/1ps
`default_nettype none
module tb_ica_core_access;
  logic sys_clk_in = 1'h0;
  logic rst_in = 1'h1;
  logic [9:0] reg_addr_in = 10'h0;
  logic [31:0] reg_wdata_in = 32'h0;
  logic reg_write_in = 1'h0;
  logic reg_read_in = 1'h0;
  logic fifo_ready_in = 1'h0;
  logic [3:0] wait_cnt = 4'h0;
  logic [31:0] reg_rdata_out, core_rdata_in;
  logic core_req_valid_out, core_ack_in, fifo_valid_out;
  logic access_pending_out, ram_read_in_progress_out;
  ica_pkg::ica_core_req_s core_req_out, last_req;
  ica_pkg::ica_fifo_word_s fifo_word_out;
  ica_pkg::ica_fifo_word_s pushed[$];
  int n_mismatch = 0;
  int n_compared = 0;
  logic [2:0] sz[3] = '{3'h1, 3'h2, 3'h4};
  logic [15:0] ofs[3] = '{16'h0013, 16'h0012, 16'h0010};
  logic [3:0] be[3] = '{4'h8, 4'hC, 4'hF};
  logic [31:0] wexp[3] = '{32'hDD00_0000, 32'hCCDD_0000, 32'hAABB_CCDD};
  logic [31:0] rexp[3] = '{32'h0000_0013, 32'h0000_1312, 32'h1312_1110};

  always #4 sys_clk_in = ~sys_clk_in;

  ica_core_access ica_core_access_i (.sys_clk_in, .rst_in, .reg_addr_in,
    .reg_wdata_in, .reg_write_in, .reg_read_in, .reg_rdata_out,
    .core_req_valid_out, .core_req_out, .core_ack_in, .core_rdata_in,
    .fifo_valid_out, .fifo_word_out, .fifo_ready_in, .access_pending_out,
    .ram_read_in_progress_out);
  ica_core_model ica_core_model_i (.sys_clk_in, .rst_in,
    .req_valid_in(core_req_valid_out), .req_in(core_req_out),
    .wait_in(wait_cnt), .ack_out(core_ack_in), .rdata_out(core_rdata_in),
    .last_req_out(last_req));

  always @(posedge sys_clk_in)
    if (fifo_valid_out === 1'h1 && fifo_ready_in) pushed.push_back(fifo_word_out);

  // ==========================================================
  // Access tasks
  task automatic chk(input logic [63:0] got, exp, input string m);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'h1;
    @(posedge sys_clk_in);
    reg_write_in <= 1'h0;
  endtask

  task automatic rd(input logic [9:0] a, input logic [31:0] e, input string m);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_read_in <= 1'h1;
    @(posedge sys_clk_in);
    reg_read_in <= 1'h0;
    #1 chk(reg_rdata_out, e, m);
  endtask

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic wait_idle();
    int i;
    for (i = 0; i < 300; i++) begin
      @(posedge sys_clk_in);
      #1;
      if (access_pending_out === 1'h0 && ram_read_in_progress_out === 1'h0)
        break;
    end
    if (i == 300) begin
      n_mismatch++;
      $display("FAIL %0t wait for idle timed out", $time);
      stop_test();
    end
  endtask

  // ==========================================================
  // Tests
  initial begin
    repeat (6) @(posedge sys_clk_in);
    rst_in <= 1'h0;
    rd(10'h304, 32'h0, "cmd reset");
    rd(10'h308, 32'h0, "len reset");
    rd(10'h300, 32'h0, "data reset");
    wr(10'h3F0, 32'hFFFF_FFFF);
    rd(10'h3F0, 32'h0, "unmapped");
    $display("test reset done");
    for (int k = 0; k < 3; k++) begin
      wait_cnt <= 4'h0;
      wr(10'h300, 32'hAABB_CCDD);
      wr(10'h304, {2'h2, 11'h0, sz[k], ofs[k]});
      wait_idle();
      chk({last_req.write, last_req.byte_en, last_req.wdata},
        {1'h1, be[k], wexp[k]}, "core write");
      chk(last_req.addr[15:2], ofs[k][15:2], "core addr");
      rd(10'h300, 32'hAABB_CCDD, "data back");
      wait_cnt <= 4'h3;
      wr(10'h304, {2'h3, 11'h0, sz[k], ofs[k]});
      wr(10'h304, 32'hC004_0020);
      wait_idle();
      chk(last_req.addr[15:2], ofs[k][15:2], "start ignored");
      rd(10'h300, rexp[k], "core read");
      rd(10'h304, {2'h1, 11'h0, sz[k], ofs[k]}, "cmd back");
    end
    wr(10'h304, 32'h4001_0008);
    #1 chk(access_pending_out, 1'h0, "zero write");
    rd(10'h304, 32'h4001_0008, "cmd fields");
    $display("test csr done");
    wr(10'h308, 32'h0006_1002);
    wr(10'h30C, 32'h8000_0000);
    repeat (10) @(posedge sys_clk_in);
    #1 chk(fifo_valid_out, 1'h1, "push held");
    rd(10'h30C, 32'h8000_0000, "busy set");
    wr(10'h308, 32'h0004_1000);
    fifo_ready_in <= 1'h1;
    wait_idle();
    chk(pushed[0], {32'h0000_0302, 3'h2}, "push 0");
    chk(pushed[1], {32'h0706_0504, 3'h4}, "push 1");
    rd(10'h308, 32'h0000_1008, "len addr");
    rd(10'h30C, 32'h0, "busy clear");
    $display("test burst done");
    stop_test();
  end
endmodule
`default_nettype wire
